/* File: src/jlp_link_param_regs.sv */
// Purpose: receive link parameter register bank with decoded controls
// Assumes: programming port delivers one-cycle write/read strobes on clk_i
// Notes: read data registered, one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module jlp_link_param_regs (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [jlp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [jlp_pkg::DATA_W-1:0] wdata_i,
  input wire logic dual_link_i,
  output logic [jlp_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic descramble_en_o,
  output logic [4:0] lanes_m1_o,
  output logic [7:0] octets_m1_o,
  output logic [7:0] octets_direct_o,
  output logic [4:0] frames_mf_m1_o,
  output logic [7:0] converters_m1_o,
  output logic [2:0] subclass_o,
  output logic [4:0] samples_m1_o,
  output logic high_density_o,
  output logic [jlp_pkg::NUM_LANES-1:0] deskew_mask_o,
  output logic [jlp_pkg::NUM_LANES-1:0] lane_en_o,
  output logic [3:0] mode_o,
  output logic mode_ok_o,
  output logic cfg_consistent_o
);
  import jlp_pkg::*;

  typedef struct packed {
    logic [7:0] scr_lanes;
    logic [7:0] oct_m1;
    logic [7:0] frm_mf;
    logic [7:0] conv;
    logic [7:0] res;
    logic [7:0] subcl;
    logic [7:0] ver;
    logic [7:0] dens;
    logic [7:0] deskew;
    logic [7:0] oct_dir;
    logic [7:0] lane_en;
    logic [7:0] rdata;
    logic rvalid;
  } jlp_state_s;

  jlp_state_s state_ff;
  jlp_state_s nxt_state;
  logic [3:0] dec_mode;
  logic dec_ok;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rvalid = rd_en_i;
    if (wr_en_i) begin
      if (hit(addr_i, OFS_SCR_LANES)) nxt_state.scr_lanes = wdata_i;
      if (hit(addr_i, OFS_OCT_M1)) nxt_state.oct_m1 = wdata_i;
      if (hit(addr_i, OFS_FRM_MF)) nxt_state.frm_mf = wdata_i;
      if (hit(addr_i, OFS_CONV)) nxt_state.conv = wdata_i;
      if (hit(addr_i, OFS_RES)) nxt_state.res = wdata_i;
      if (hit(addr_i, OFS_SUBCL)) nxt_state.subcl = wdata_i;
      if (hit(addr_i, OFS_VER)) nxt_state.ver = wdata_i;
      if (hit(addr_i, OFS_DENS)) nxt_state.dens = wdata_i;
      if (hit(addr_i, OFS_DESKEW)) nxt_state.deskew = wdata_i;
      if (hit(addr_i, OFS_OCT_DIR)) nxt_state.oct_dir = wdata_i;
      if (hit(addr_i, OFS_LANE_EN)) nxt_state.lane_en = wdata_i;
    end
    // read returns stored byte; unmapped addresses read zero
    if (rd_en_i) begin
      unique case (addr_i)
        OFS_SCR_LANES: nxt_state.rdata = state_ff.scr_lanes;
        OFS_OCT_M1: nxt_state.rdata = state_ff.oct_m1;
        OFS_FRM_MF: nxt_state.rdata = state_ff.frm_mf;
        OFS_CONV: nxt_state.rdata = state_ff.conv;
        OFS_RES: nxt_state.rdata = state_ff.res;
        OFS_SUBCL: nxt_state.rdata = state_ff.subcl;
        OFS_VER: nxt_state.rdata = state_ff.ver;
        OFS_DENS: nxt_state.rdata = state_ff.dens;
        OFS_DESKEW: nxt_state.rdata = state_ff.deskew;
        OFS_OCT_DIR: nxt_state.rdata = state_ff.oct_dir;
        OFS_LANE_EN: nxt_state.rdata = state_ff.lane_en;
        default: nxt_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff.scr_lanes <= RST_SCR_LANES;
      state_ff.oct_m1 <= RST_OCT_M1;
      state_ff.frm_mf <= RST_FRM_MF;
      state_ff.conv <= RST_CONV;
      state_ff.res <= RST_RES;
      state_ff.subcl <= RST_SUBCL;
      state_ff.ver <= RST_VER;
      state_ff.dens <= RST_DENS;
      state_ff.deskew <= RST_DESKEW;
      state_ff.oct_dir <= RST_OCT_DIR;
      state_ff.lane_en <= RST_LANE_EN;
      state_ff.rdata <= 8'h00;
      state_ff.rvalid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata_o = state_ff.rdata;
  assign rvalid_o = state_ff.rvalid;
  assign descramble_en_o = state_ff.scr_lanes[BIT_SCR_EN];
  assign lanes_m1_o = state_ff.scr_lanes[FLD5_MSB:0];
  assign octets_m1_o = state_ff.oct_m1;
  assign octets_direct_o = state_ff.oct_dir;
  assign frames_mf_m1_o = state_ff.frm_mf[FLD5_MSB:0];
  assign converters_m1_o = state_ff.conv;
  assign subclass_o = state_ff.subcl[DATA_W-1:SUBCL_LSB];
  assign samples_m1_o = state_ff.ver[FLD5_MSB:0];
  assign high_density_o = state_ff.dens[BIT_HD];
  assign deskew_mask_o = state_ff.deskew;
  assign lane_en_o = state_ff.lane_en;

  jlp_mode_decode u_mode (
    .lanes_m1_i(state_ff.scr_lanes[FLD5_MSB:0]),
    .oct_m1_i(state_ff.oct_m1),
    .conv_m1_i(state_ff.conv),
    .samp_m1_i(state_ff.ver[FLD5_MSB:0]),
    .dual_link_i(dual_link_i),
    .mode_o(dec_mode),
    .mode_ok_o(dec_ok)
  );
  assign mode_o = dec_mode;
  assign mode_ok_o = dec_ok;

  // flags host-side slips; the block still runs with what was written
  assign cfg_consistent_o = (state_ff.oct_dir == state_ff.oct_m1 + 8'h01)
    && (state_ff.res == RST_RES)
    && (state_ff.subcl[FLD5_MSB:0] == RST_SUBCL[FLD5_MSB:0])
    && (state_ff.ver[DATA_W-1:SUBCL_LSB] == RST_VER[DATA_W-1:SUBCL_LSB])
    && (state_ff.dens[FLD5_MSB:0] == 5'h00);
endmodule // jlp_link_param_regs
`default_nettype wire

/* File: src/jlp_mode_decode.sv */
// Purpose: recognise which of modes 3 to 6 the parameter set describes
// Assumes: inputs come from registers on the same clock
// Notes: purely combinational; unknown sets report no mode
`timescale 1ns/1ps
`default_nettype none
module jlp_mode_decode (
  input wire logic [4:0] lanes_m1_i,
  input wire logic [7:0] oct_m1_i,
  input wire logic [7:0] conv_m1_i,
  input wire logic [4:0] samp_m1_i,
  input wire logic dual_link_i,
  output logic [3:0] mode_o,
  output logic mode_ok_o
);
  import jlp_pkg::*;
  always_comb begin
    mode_o = MODE_NONE;
    if (lanes_m1_i == 5'h01 && oct_m1_i == 8'h03 && conv_m1_i == 8'h03) begin
      mode_o = 4'h3;
    end else if (lanes_m1_i == 5'h03 && oct_m1_i == 8'h00 && conv_m1_i == 8'h01) begin
      mode_o = 4'h4;
    end else if (lanes_m1_i == 5'h03 && oct_m1_i == 8'h01 && conv_m1_i == 8'h01 && samp_m1_i == 5'h01) begin
      mode_o = 4'h5;
    end else if (lanes_m1_i == 5'h01 && oct_m1_i == 8'h01 && conv_m1_i == 8'h01 && samp_m1_i == 5'h00) begin
      mode_o = 4'h6;
    end
    // low modes only run single link
    mode_ok_o = (mode_o != MODE_NONE) && (!dual_link_i || mode_o >= 4'(MODE_DUAL_MIN));
  end
endmodule // jlp_mode_decode
`default_nettype wire

/* File: src/jlp_pkg.sv */
// Purpose: constants for the receive link parameter register bank
// Assumes: 12-bit register address, 8-bit data
// Notes: reset values are the mode 4 settings (four lanes, one octet)
package jlp_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_LANES = 8;
  localparam int unsigned NUM_REGS = 11;
  localparam logic [11:0] OFS_SCR_LANES = 12'h453;
  localparam logic [11:0] OFS_OCT_M1 = 12'h454;
  localparam logic [11:0] OFS_FRM_MF = 12'h455;
  localparam logic [11:0] OFS_CONV = 12'h456;
  localparam logic [11:0] OFS_RES = 12'h457;
  localparam logic [11:0] OFS_SUBCL = 12'h458;
  localparam logic [11:0] OFS_VER = 12'h459;
  localparam logic [11:0] OFS_DENS = 12'h45a;
  localparam logic [11:0] OFS_DESKEW = 12'h46c;
  localparam logic [11:0] OFS_OCT_DIR = 12'h476;
  localparam logic [11:0] OFS_LANE_EN = 12'h47d;
  localparam int unsigned BIT_SCR_EN = 7;
  localparam int unsigned BIT_HD = 7;
  localparam int unsigned FLD5_MSB = 4;
  localparam int unsigned SUBCL_LSB = 5;
  localparam int unsigned MODE_DUAL_MIN = 4;
  localparam logic [7:0] RST_SCR_LANES = 8'h03;
  localparam logic [7:0] RST_OCT_M1 = 8'h00;
  localparam logic [7:0] RST_FRM_MF = 8'h1f;
  localparam logic [7:0] RST_CONV = 8'h01;
  localparam logic [7:0] RST_RES = 8'h0f;
  localparam logic [7:0] RST_SUBCL = 8'h0f;
  localparam logic [7:0] RST_VER = 8'h20;
  localparam logic [7:0] RST_DENS = 8'h80;
  localparam logic [7:0] RST_DESKEW = 8'h0f;
  localparam logic [7:0] RST_OCT_DIR = 8'h01;
  localparam logic [7:0] RST_LANE_EN = 8'h0f;
  localparam logic [3:0] MODE_NONE = 4'hf;
endpackage

/* File: tb/jlp_host_model.sv */
// Purpose: host side link mode select
// Assumes: level held while programming
// Notes: stands in for the link-mode register
`timescale 1ns/1ps
`default_nettype none
module jlp_host_model (
  input wire logic clk_i,
  input wire logic dual_req_i,
  output logic dual_link_o
);
  always_ff @(posedge clk_i) begin
    dual_link_o <= dual_req_i;
  end
endmodule // jlp_host_model
`default_nettype wire

/* File: tb/jlp_regs_monitor.sv */
// Purpose: port checker for the link parameter bank
// Assumes: one clock, sync reset
// Notes: bound onto every bank instance
`timescale 1ns/1ps
`default_nettype none
module jlp_regs_monitor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic dual_link_i,
  input wire logic rvalid_o,
  input wire logic descramble_en_o,
  input wire logic [4:0] lanes_m1_o,
  input wire logic [7:0] octets_m1_o,
  input wire logic [7:0] converters_m1_o,
  input wire logic [2:0] subclass_o,
  input wire logic [4:0] samples_m1_o,
  input wire logic high_density_o,
  input wire logic [7:0] lane_en_o,
  input wire logic [7:0] deskew_mask_o,
  input wire logic [3:0] mode_o,
  input wire logic mode_ok_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_wr(logic [11:0] a);
    wr_en_i && addr_i == a;
  endsequence
  a_read_answer: assert property (rd_en_i |=> rvalid_o) else $error("read not answered");
  a_rvalid_pulse: assert property (!rd_en_i |=> !rvalid_o) else $error("stray rvalid");
  a_lane_write: assert property (
    s_wr(12'h453) |=> descramble_en_o == $past(wdata_i[7]) && lanes_m1_o == $past(wdata_i[4:0]))
    else $error("lane reg wrong");
  a_octet_write: assert property (s_wr(12'h454) |=> octets_m1_o == $past(wdata_i))
    else $error("octets wrong");
  a_conv_write: assert property (s_wr(12'h456) |=> converters_m1_o == $past(wdata_i))
    else $error("converters wrong");
  a_subcl_write: assert property (s_wr(12'h458) |=> subclass_o == $past(wdata_i[7:5]))
    else $error("subclass wrong");
  a_samp_write: assert property (s_wr(12'h459) |=> samples_m1_o == $past(wdata_i[4:0]))
    else $error("samples wrong");
  a_hd_write: assert property (s_wr(12'h45a) |=> high_density_o == $past(wdata_i[7]))
    else $error("density wrong");
  a_mask_hold: assert property (!wr_en_i |=> $stable(lane_en_o) && $stable(deskew_mask_o))
    else $error("mask changed");
  a_dual_low: assert property (dual_link_i && mode_o < 4'h4 |-> !mode_ok_o)
    else $error("low mode in dual");
endmodule // jlp_regs_monitor
bind jlp_link_param_regs jlp_regs_monitor u_jlp_regs_monitor (.*);
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: register level test of the link parameter bank
// Assumes: one-cycle strobes, read answered next cycle
// Notes: mode tables hold bytes in address order
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import jlp_pkg::*;
  logic clk_i = 0, srst_i = 1, wr_en_i = 0, rd_en_i = 0, dual_req = 0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0] wdata_i = 8'h00, rdata_o, lane_en_o, deskew_mask_o, octets_m1_o, octets_direct_o, converters_m1_o;
  logic [4:0] lanes_m1_o, frames_mf_m1_o, samples_m1_o;
  logic [3:0] mode_o;
  logic [2:0] subclass_o;
  logic rvalid_o, descramble_en_o, high_density_o, mode_ok_o, cfg_consistent_o, dual_link_i;
  int n_mismatch = 0, compares = 0;
  logic [11:0] ofs [11] = '{OFS_SCR_LANES, OFS_OCT_M1, OFS_FRM_MF, OFS_CONV, OFS_RES, OFS_SUBCL,
    OFS_VER, OFS_DENS, OFS_DESKEW, OFS_OCT_DIR, OFS_LANE_EN};
  logic [87:0] rst_v = 88'h03001f010f0f20800f010f;
  logic [87:0] tbl [3:6] = '{88'h81031f030f2f2000030403, 88'h83001f010f2f20800f010f,
    88'h03010f010f0f21000f020f, 88'h01010f010f0f2000030203};
  jlp_link_param_regs u_jlp_link_param_regs (.*);
  jlp_host_model u_jlp_host_model (.clk_i(clk_i), .dual_req_i(dual_req), .dual_link_o(dual_link_i));
  initial forever #25 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    @(negedge clk_i);
    chk("rvalid", 8'(rvalid_o), 8'h01);
    chk("rdata", rdata_o, exp);
  endtask
  task automatic results;
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    logic [87:0] t;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 11; i++) rd(ofs[i], rst_v[8*(10-i)+:8]);
    chk("mode", 8'(mode_o), 8'h04);
    for (int m = 3; m < 7; m++) begin
      t = tbl[m];
      for (int i = 0; i < 11; i++) wr(ofs[i], t[8*(10-i)+:8]);
      for (int i = 0; i < 11; i++) rd(ofs[i], t[8*(10-i)+:8]);
      chk("scr", 8'(descramble_en_o), 8'(t[87]));
      chk("lanes", 8'(lanes_m1_o), 8'(t[84:80]));
      chk("oct", octets_m1_o, t[79:72]);
      chk("oct_dir", octets_direct_o, t[15:8]);
      chk("frm", 8'(frames_mf_m1_o), 8'(t[68:64]));
      chk("conv", converters_m1_o, t[63:56]);
      chk("subcl", 8'(subclass_o), 8'(t[47:45]));
      chk("samp", 8'(samples_m1_o), 8'(t[36:32]));
      chk("hd", 8'(high_density_o), 8'(t[31]));
      chk("deskew", deskew_mask_o, t[23:16]);
      chk("lane_en", lane_en_o, t[7:0]);
      chk("mode", 8'(mode_o), 8'(m));
      chk("cons", 8'(cfg_consistent_o), 8'h01);
      @(posedge clk_i);
      dual_req <= 1'b1;
      repeat (3) @(negedge clk_i);
      chk("dual_ok", 8'(mode_ok_o), 8'(m > 3));
      @(posedge clk_i);
      dual_req <= 1'b0;
    end
    // unmapped write must leave nothing behind
    wr(12'h460, 8'h5a);
    rd(12'h460, 8'h00);
    wr(OFS_OCT_DIR, 8'h04);
    @(negedge clk_i);
    chk("cons", 8'(cfg_consistent_o), 8'h00);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(OFS_OCT_DIR, 8'h01);
    results();
  end
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
endmodule // tb_top
`default_nettype wire
